// ### hdl/xma_map.vh
// Purpose: constants for the extended memory arithmetic unit
// Assumes: included by the unit and its monitor
// Notes: operation codes are local to this unit
`ifndef XMA_MAP_VH
`define XMA_MAP_VH
`define XMA_OP_NORM 4'h0
`define XMA_OP_ADD 4'h1
`define XMA_OP_SUB 4'h2
`define XMA_OP_SWAP 4'h3
`define XMA_OP_SETB 4'h4
`define XMA_OP_CLRB 4'h5
`define XMA_OP_CPLB 4'h6
`define XMA_OP_TSTB 4'h7
`define XMA_OP_DECS 4'h8
`define XMA_NORM_MAX 5'h1f
`define XMA_IND_BIT 15
`define XMA_SIGN_BIT 15
`define XMA_NEXT_BIT 14
`endif

// ### hdl/xma_unit.v
// Purpose: execution datapath for extended memory arithmetic instructions
// Assumes: a single memory port with one-cycle read latency; sequencer holds
//          start for one cycle with op, operands and registers valid
// Notes: byte addresses select the high byte when bit 0 is clear
//        each pointer in an indirect chain costs two cycles
`timescale 1ns/1ps
`include "xma_map.vh"
// Contract
// - Normalize shifts left until bits 15,14 differ
// - Pair is 31-bit magnitude plus sign
// - Flag cleared if normalized, else set
// - Exponent cell decremented once per shift
// - Supplied count limits shifts, else default
// - Zero count only tests normalization
// - Index ops two words, indirect word only
// - Byte mode flag selects byte addressing
// - Word add to index, overflow flagged
// - Byte add to index, overflow flagged
// - Word subtract from index, overflow flagged
// - Byte subtract from index, overflow flagged
// - Swap index with memory word
// - Swap low byte, clear high byte
// - Bit position from first word, word mode
// - Set bit, old value to flag
// - Clear bit, old value to flag
// - Invert bit, old value to flag
// - Test bit copies into flag only
// - Decrement word, postindex, ignores byte mode
// - Interrupt form at minus one echoes
// - In-line form skips at minus one
// - Indexing added after indirection
module xma_unit #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Sequencer request
    input wire start,
    input wire [3:0] op,
    input wire [15:0] addr_word,
    input wire [3:0] bit_pos,
    input wire [4:0] shift_count,
    input wire count_given,
    input wire byte_mode,
    input wire indexed,
    input wire intr_form,
    input wire [15:0] acc_in,
    input wire [15:0] idx_in,
    input wire flag_in,
    // Sequencer results
    output reg done,
    output reg [15:0] acc_out,
    output reg [15:0] idx_out,
    output reg arith_excess_flag,
    output reg skip_next,
    output reg interrupt_acknowledge_pulse,
    // Memory port
    output reg mem_rd,
    output reg mem_wr,
    output reg [ADDR_W-1:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire [15:0] mem_rdata
);
    // One-hot sequencer states
    localparam ST_IDLE = 6'b000001;
    localparam ST_IND = 6'b000010;
    localparam ST_READ = 6'b000100;
    localparam ST_EXEC = 6'b001000;
    localparam ST_SHIFT = 6'b010000;
    localparam ST_DONE = 6'b100000;

    // Signed overflow of a 16-bit sum
    function ovf;
        input a_s;
        input b_s;
        input r_s;
        begin
            ovf = (a_s == b_s) && (r_s != a_s);
        end
    endfunction

    // Opcodes whose operand follows the byte mode flag
    function is_index_op;
        input [3:0] code;
        begin
            is_index_op = (code == `XMA_OP_ADD) || (code == `XMA_OP_SUB) || (code == `XMA_OP_SWAP);
        end
    endfunction

    // Word address from a pointer; bit 15 marks indirection, not address
    function [15:0] cell_addr;
        input [15:0] ptr;
        begin
            cell_addr = {1'b0, ptr[14:0]};
        end
    endfunction

    // Request latched at start; results build in the output registers
    reg [5:0] state;
    reg [3:0] op_r;
    reg [3:0] bpos;
    reg bmode;
    reg idx_sel;
    reg ind_pend;
    reg intr_r;
    reg byte_lo;
    reg [4:0] shifts_left;
    reg [15:0] word;
    reg [15:0] sum;
    reg sum_ovf;
    reg [15:0] operand;
    reg [15:0] flipped;
    // Word addresses for the first fetch and for each pointer in a chain
    wire [15:0] direct_addr = cell_addr(addr_word);
    wire [15:0] chain_addr = cell_addr(mem_rdata);
    // A byte address names its word by dropping the byte select bit
    wire [15:0] byte_cell = {1'b0, addr_word[15:1]};

    // Byte operand, bit-flipped word and index sum from the fetched word
    always @* begin
        operand = bmode ? {8'h00, (byte_lo ? mem_rdata[7:0] : mem_rdata[15:8])} : mem_rdata;
        flipped = mem_rdata ^ (16'h0001 << bpos);
        sum = 16'h0000;
        sum_ovf = 1'b0;
        if (op_r == `XMA_OP_SUB) begin
            sum = idx_out - operand;
            sum_ovf = ovf(idx_out[15], ~operand[15], sum[15]);
        end else if (op_r == `XMA_OP_DECS) begin
            sum = mem_rdata - 16'h0001;
            sum_ovf = ovf(mem_rdata[15], 1'b1, sum[15]);
        end else begin
            sum = idx_out + operand;
            sum_ovf = ovf(idx_out[15], operand[15], sum[15]);
        end
    end

    // Main sequencer
    always @(posedge ref_clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            op_r <= 4'h0;
            bpos <= 4'h0;
            bmode <= 1'b0;
            idx_sel <= 1'b0;
            ind_pend <= 1'b0;
            intr_r <= 1'b0;
            byte_lo <= 1'b0;
            shifts_left <= 5'h00;
            word <= 16'h0000;
            done <= 1'b0;
            acc_out <= 16'h0000;
            idx_out <= 16'h0000;
            arith_excess_flag <= 1'b0;
            skip_next <= 1'b0;
            interrupt_acknowledge_pulse <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_wdata <= 16'h0000;
        end else begin
            done <= 1'b0;
            skip_next <= 1'b0;
            interrupt_acknowledge_pulse <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        op_r <= op;
                        bpos <= bit_pos;
                        bmode <= byte_mode && is_index_op(op);
                        idx_sel <= indexed && (op == `XMA_OP_DECS);
                        intr_r <= intr_form;
                        acc_out <= acc_in;
                        idx_out <= idx_in;
                        arith_excess_flag <= flag_in;
                        shifts_left <= count_given ? shift_count : `XMA_NORM_MAX;
                        mem_rd <= 1'b1;
                        if (byte_mode && is_index_op(op)) begin
                            // Byte operands never chain through pointers
                            byte_lo <= addr_word[0];
                            ind_pend <= 1'b0;
                            mem_addr <= byte_cell[ADDR_W-1:0];
                        end else begin
                            byte_lo <= 1'b0;
                            ind_pend <= addr_word[`XMA_IND_BIT];
                            mem_addr <= direct_addr[ADDR_W-1:0];
                        end
                        // Read data lags a cycle, so every fetch waits in READ
                        state <= ST_READ;
                    end
                end
                ST_IND: begin
                    mem_rd <= 1'b1;
                    mem_addr <= chain_addr[ADDR_W-1:0];
                    ind_pend <= mem_rdata[`XMA_IND_BIT];
                    state <= ST_READ;
                end
                ST_READ: begin
                    // Word fetched on the last edge is not valid until the next
                    if (ind_pend) begin
                        state <= ST_IND;
                    end else if (idx_sel) begin
                        mem_rd <= 1'b1;
                        mem_addr <= mem_addr + idx_out[ADDR_W-1:0];
                        idx_sel <= 1'b0;
                    end else begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    word <= mem_rdata;
                    state <= ST_DONE;
                    case (op_r)
                        `XMA_OP_ADD, `XMA_OP_SUB: begin
                            idx_out <= sum;
                            if (sum_ovf)
                                arith_excess_flag <= 1'b1;
                        end
                        `XMA_OP_SWAP: begin
                            mem_wr <= 1'b1;
                            if (bmode) begin
                                mem_wdata <= byte_lo ? {mem_rdata[15:8], idx_out[7:0]} : {idx_out[7:0], mem_rdata[7:0]};
                                idx_out <= operand;
                            end else begin
                                mem_wdata <= idx_out;
                                idx_out <= mem_rdata;
                            end
                        end
                        `XMA_OP_SETB, `XMA_OP_CLRB, `XMA_OP_CPLB, `XMA_OP_TSTB: begin
                            arith_excess_flag <= mem_rdata[bpos];
                            mem_wr <= (op_r != `XMA_OP_TSTB);
                            if (op_r == `XMA_OP_SETB)
                                mem_wdata <= mem_rdata | (16'h0001 << bpos);
                            else if (op_r == `XMA_OP_CLRB)
                                mem_wdata <= mem_rdata & ~(16'h0001 << bpos);
                            else
                                mem_wdata <= flipped;
                        end
                        `XMA_OP_DECS: begin
                            mem_wr <= 1'b1;
                            mem_wdata <= sum;
                            if (sum == 16'hffff) begin
                                if (intr_r)
                                    interrupt_acknowledge_pulse <= 1'b1;
                                else
                                    skip_next <= 1'b1;
                            end else if (sum_ovf) begin
                                arith_excess_flag <= 1'b1;
                            end
                        end
                        default: begin
                            // Normalize: memory word is the exponent
                            state <= ST_SHIFT;
                        end
                    endcase
                end
                ST_SHIFT: begin
                    // stop when normalized or count spent
                    if (acc_out[`XMA_SIGN_BIT] != acc_out[`XMA_NEXT_BIT]) begin
                        arith_excess_flag <= 1'b0;
                        mem_wr <= 1'b1;
                        mem_wdata <= word;
                        state <= ST_DONE;
                    end else if (shifts_left == 5'h00) begin
                        arith_excess_flag <= 1'b1;
                        mem_wr <= 1'b1;
                        mem_wdata <= word;
                        state <= ST_DONE;
                    end else begin
                        // sign kept, top magnitude bit lost, index bit 15 carried
                        acc_out <= {acc_out[15], acc_out[13:0], idx_out[15]};
                        idx_out <= {idx_out[14:0], 1'b0};
                        word <= word - 16'h0001;
                        shifts_left <= shifts_left - 5'h01;
                    end
                end
                ST_DONE: begin
                    // Results already stand; done marks them settled
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// ### sim/xma_unit_monitor.sv
// Purpose: checker for the extended memory arithmetic unit
// Assumes: requests keep the hand-over spacing
// Notes: request fields and the last word read are latched here
`timescale 1ns/1ps
`include "xma_map.vh"
module xma_unit_monitor (
    // Clock, reset and request
    input wire ref_clk, input wire resetn, input wire start, input wire [3:0] op, input wire [3:0] bit_pos,
    input wire byte_mode, input wire intr_form, input wire [15:0] idx_in,
    // Results and memory
    input wire done, input wire [15:0] idx_out, input wire arith_excess_flag, input wire skip_next,
    input wire interrupt_acknowledge_pulse, input wire mem_rd, input wire mem_wr, input wire [15:0] mem_wdata,
    input wire [15:0] mem_rdata
);
    reg [3:0] op_q, bp_q;
    reg bm_q, it_q, rd_d;
    reg [15:0] ix_q, rd_q;
    wire [15:0] mk = 16'h0001 << bp_q;
    // The last word read is the operand of the write-back, even after indirection
    always @(posedge ref_clk) begin
        rd_d <= mem_rd;
        if (rd_d) rd_q <= mem_rdata;
        if (start) {op_q, bp_q, bm_q, it_q, ix_q} <= {op, bit_pos, byte_mode, intr_form, idx_in};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_take; start ##1 mem_rd; endsequence
    property p_take; start |=> mem_rd; endproperty
    a_take: assert property (p_take) else $error("no read after request");
    property p_done; s_take |-> ##[2:60] done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_setb; mem_wr && op_q == `XMA_OP_SETB |-> mem_wdata == (rd_q | mk); endproperty
    a_setb: assert property (p_setb) else $error("set bit data");
    property p_clrb; mem_wr && op_q == `XMA_OP_CLRB |-> mem_wdata == (rd_q & ~mk); endproperty
    a_clrb: assert property (p_clrb) else $error("clear bit data");
    property p_cplb; mem_wr && op_q == `XMA_OP_CPLB |-> mem_wdata == (rd_q ^ mk); endproperty
    a_cplb: assert property (p_cplb) else $error("invert bit data");
    property p_tstb; done && op_q[3:2] == 2'b01 |-> arith_excess_flag == |(rd_q & mk); endproperty
    a_tstb: assert property (p_tstb) else $error("bit flag");
    property p_decw; mem_wr && op_q == `XMA_OP_DECS |-> mem_wdata == rd_q - 16'h0001; endproperty
    a_decw: assert property (p_decw) else $error("decrement data");
    property p_skip; skip_next |-> mem_wr && !it_q && mem_wdata == 16'hffff; endproperty
    a_skip: assert property (p_skip) else $error("bad skip");
    property p_ack; interrupt_acknowledge_pulse |-> mem_wr && it_q && mem_wdata == 16'hffff; endproperty
    a_ack: assert property (p_ack) else $error("bad echo");
    property p_swap; mem_wr && op_q == `XMA_OP_SWAP && !bm_q |-> mem_wdata == ix_q; endproperty
    a_swap: assert property (p_swap) else $error("swap data");
    property p_add; done && op_q == `XMA_OP_ADD && !bm_q |-> idx_out == ix_q + rd_q; endproperty
    a_add: assert property (p_add) else $error("add result");
    property p_sub; done && op_q == `XMA_OP_SUB && !bm_q |-> idx_out == ix_q - rd_q; endproperty
    a_sub: assert property (p_sub) else $error("subtract result");
    property p_swpb; done && op_q == `XMA_OP_SWAP && bm_q |-> idx_out[15:8] == 8'h00; endproperty
    a_swpb: assert property (p_swpb) else $error("byte swap high byte");
endmodule
bind xma_unit xma_unit_monitor i_xma_unit_monitor (.ref_clk, .resetn, .start, .op, .bit_pos, .byte_mode,
    .intr_form, .idx_in, .done, .idx_out, .arith_excess_flag, .skip_next, .interrupt_acknowledge_pulse,
    .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

// ### sim/xma_mem_model.sv
// Purpose: main memory model facing the unit
// Assumes: one-cycle read latency, 256 words
// Notes: data lines flip when not read, so stale data never passes
`timescale 1ns/1ps
module xma_mem_model (
    // Memory port
    input wire ref_clk, input wire mem_rd, input wire mem_wr, input wire [15:0] mem_addr,
    input wire [15:0] mem_wdata, output reg [15:0] mem_rdata
);
    reg [15:0] m [0:255];
    initial mem_rdata = 16'h0000;
    // Read answers next cycle; otherwise the inverse of the last value
    always @(posedge ref_clk) begin
        if (mem_wr) m[mem_addr[7:0]] <= mem_wdata;
        mem_rdata <= mem_rd ? m[mem_addr[7:0]] : ~mem_rdata;
    end
endmodule

// ### sim/xma_unit_tb.sv
// Purpose: self-checking bench for the extended memory arithmetic unit
// Assumes: memory model at the far side
// Notes: a decoy word sits at the raw byte address to catch wrong addressing
`timescale 1ns/1ps
`define M i_xma_mem_model.m
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module xma_unit_tb;
    reg ref_clk = 0, resetn = 0, start = 0, count_given = 0, byte_mode = 0, indexed = 0, intr_form = 0, flag_in = 0;
    reg [3:0] op = 0, bit_pos = 0;
    reg [4:0] shift_count = 0;
    reg [15:0] addr_word = 0, acc_in = 0, idx_in = 0, e;
    wire done, arith_excess_flag, skip_next, interrupt_acknowledge_pulse, mem_rd, mem_wr;
    wire [15:0] acc_out, idx_out, mem_addr, mem_wdata, mem_rdata;
    integer failures = 0, num_checks = 0, k;
    bit sk, ak;
    xma_unit i_xma_unit (.ref_clk, .resetn, .start, .op, .addr_word, .bit_pos, .shift_count, .count_given,
        .byte_mode, .indexed, .intr_form, .acc_in, .idx_in, .flag_in, .done, .acc_out, .idx_out,
        .arith_excess_flag, .skip_next, .interrupt_acknowledge_pulse, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
        .mem_rdata);
    xma_mem_model i_xma_mem_model (.ref_clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
    always #2.5 ref_clk = ~ref_clk;
    // One request, then wait for done while collecting pulses
    task go(input [3:0] o, input [15:0] a, input [15:0] x, input [3:0] b, input bm, input ix, input it);
        integer n;
        begin
            @(posedge ref_clk);
            {start, op, addr_word, idx_in, bit_pos, byte_mode, indexed, intr_form} <= {1'b1, o, a, x, b, bm, ix, it};
            @(posedge ref_clk);
            start <= 1'b0;
            {sk, ak, n} = 0;
            while (done !== 1'b1 && n < 100) begin
                @(posedge ref_clk); #1;
                sk |= skip_next; ak |= interrupt_acknowledge_pulse; n++;
            end
            if (n >= 100) failures++;
        end
    endtask
    task t_arith;
        begin
            `M[1] = 16'h0001;
            go(4'h1, 16'h0001, 16'h7fff, 0, 0, 0, 0); `CHK(idx_out, 16'h8000) `CHK(arith_excess_flag, 1'b1)
            go(4'h2, 16'h0001, 16'h8000, 0, 0, 0, 0); `CHK(idx_out, 16'h7fff) `CHK(arith_excess_flag, 1'b1)
            `M[8'h20] = 16'h1234; `M[8'h41] = 16'h5678;
            go(4'h1, 16'h0041, 16'h0010, 0, 1, 0, 0); `CHK(idx_out, 16'h0044) `CHK(arith_excess_flag, 1'b0)
            go(4'h2, 16'h0041, 16'h0044, 0, 1, 0, 0); `CHK(idx_out, 16'h0010)
        end
    endtask
    task t_swap;
        begin
            go(4'h3, 16'h0041, 16'habcd, 0, 1, 0, 0); `CHK(idx_out, 16'h0034)
            `CHK(`M[8'h20], 16'h12cd)
            `CHK(`M[8'h41], 16'h5678)
            `M[8'h30] = 16'h0031; `M[8'h31] = 16'h5555;
            go(4'h3, 16'h8030, 16'h0abc, 0, 0, 0, 0); `CHK(idx_out, 16'h5555) `CHK(`M[8'h31], 16'h0abc)
        end
    endtask
    task t_bits;
        begin
            for (k = 0; k < 8; k++) begin
                `M[8'h60] = 16'h0008;
                e = 16'h0001 << (k < 4 ? 3 : 15);
                e = (k % 4 == 0) ? 16'h0008 | e : (k % 4 == 1) ? 16'h0008 & ~e : (k % 4 == 2) ? 16'h0008 ^ e : 16'h0008;
                go(4'h4 + k % 4, 16'h0060, 0, k < 4 ? 3 : 15, 1, 0, 0); // Byte mode set on purpose
                `CHK(`M[8'h60], e) `CHK(arith_excess_flag, k < 4)
            end
        end
    endtask
    task t_dec;
        begin
            `M[8'h42] = 16'h0000;
            go(4'h8, 16'h0040, 16'h0002, 0, 1, 1, 0); `CHK(`M[8'h42], 16'hffff) `CHK(sk, 1'b1)
            @(posedge ref_clk); flag_in <= 1'b1; `M[8'h42] = 16'h0000;
            go(4'h8, 16'h0040, 16'h0002, 0, 0, 1, 1); `CHK({ak, sk, arith_excess_flag}, 3'b101)
            @(posedge ref_clk); flag_in <= 1'b0; `M[8'h44] = 16'h8000;
            go(4'h8, 16'h0044, 0, 0, 0, 0, 0); `CHK(`M[8'h44], 16'h7fff) `CHK({sk, arith_excess_flag}, 2'b01)
            @(posedge ref_clk); flag_in <= 1'b0; `M[8'h70] = 16'h8072; `M[8'h72] = 16'h0074; `M[8'h76] = 16'h0005;
            go(4'h8, 16'h8070, 16'h0002, 0, 0, 1, 0); `CHK(`M[8'h76], 16'h0004)
            `CHK({sk, arith_excess_flag}, 2'b00)
        end
    endtask
    task t_norm(input cg, input [4:0] c, input [15:0] ea, input [15:0] ex, input f, input [15:0] ee);
        begin
            @(posedge ref_clk); {acc_in, count_given, shift_count} <= {16'h1000, cg, c}; `M[8'h50] = 16'h0005;
            go(4'h0, 16'h0050, 16'h0001, 0, 0, 0, 0); `CHK(acc_out, ea) `CHK(idx_out, ex)
            `CHK(arith_excess_flag, f) `CHK(`M[8'h50], ee)
        end
    endtask
    task results;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #100000; failures++; results;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        t_arith; t_swap; t_bits; t_dec;
        t_norm(0, 0, 16'h4000, 16'h0004, 0, 16'h0003);
        t_norm(1, 1, 16'h2000, 16'h0002, 1, 16'h0004);
        t_norm(1, 0, 16'h1000, 16'h0001, 1, 16'h0005);
        results;
    end
endmodule
